// File: hdl/bcd_year_counter.sv
// Four-digit BCD year counter, kept through every reset
`timescale 1ns/10ps
module bcd_year_counter (
  input wire logic clk, // System clock
  input wire logic inc, // One-cycle year carry
  input wire logic [1:0] wr_en, // Byte-lane write enables
  input wire logic [15:0] wr_data, // Write data
  output logic [15:0] year // BCD year
);
  logic [15:0] next_year;
  logic carry;

  // Ripple increment across the four digits
  always_comb begin
    next_year = year;
    carry = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (carry) begin
        next_year[4*i +: 4] = rtc_cal_pkg::bcd_digit_inc(year[4*i +: 4]);
      end
      carry = carry && (year[4*i +: 4] == rtc_cal_pkg::BCD_NINE);
    end
  end

  // No reset: contents survive reset and standby
  always_ff @(posedge clk) begin
    if (wr_en != 2'b00) begin
      if (wr_en[0]) begin
        year[7:0] <= wr_data[7:0];
      end
      if (wr_en[1]) begin
        year[15:8] <= wr_data[15:8];
      end
    end else if (inc) begin
      year <= next_year;
    end
  end
endmodule

// File: hdl/leap_year_detect.sv
// Leap-year detection from a four-digit BCD year
`timescale 1ns/10ps
module leap_year_detect (
  input wire logic [15:0] year, // BCD year
  output logic leap // High in a leap year
);
  logic low_zero;

  // Divisible by 4, and by 400 when divisible by 100; 0000 falls out as leap
  always_comb begin
    low_zero = (year[7:0] == 8'h00);
    leap = rtc_cal_pkg::bcd_div4(year[7:4], year[3:0]) &&
      (!low_zero || rtc_cal_pkg::bcd_div4(year[15:12], year[11:8]));
  end
endmodule

// File: hdl/rtc_cal_pkg.sv
// Shared constants, field layouts, types and helpers of the calendar counters
package rtc_cal_pkg;

  // Register byte offsets on the register bus
  localparam logic [7:0] WEEKDAY_OFS = 8'h00;
  localparam logic [7:0] DATE_OFS = 8'h04;
  localparam logic [7:0] MONTH_OFS = 8'h08;
  localparam logic [7:0] YEAR_OFS = 8'h0c;
  localparam logic [7:0] CTRL_OFS = 8'h10;

  // Field positions
  localparam int WEEKDAY_MSB = 2;
  localparam int DATE_MSB = 5;
  localparam int MONTH_MSB = 4;
  localparam int YEAR_MSB = 15;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_LEAP_BIT = 1;

  // Reset values of control state
  localparam logic CTRL_RUN_RESET = 1'b0;

  // Weekday codes
  localparam logic [2:0] SUNDAY = 3'h0;
  localparam logic [2:0] SATURDAY = 3'h6;

  // BCD calendar limits
  localparam logic [7:0] DATE_FIRST = 8'h01;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;
  localparam logic [7:0] MONTH_FIRST = 8'h01;
  localparam logic [7:0] MONTH_LAST = 8'h12;
  localparam logic [7:0] FEBRUARY = 8'h02;
  localparam logic [7:0] APRIL = 8'h04;
  localparam logic [7:0] JUNE = 8'h06;
  localparam logic [7:0] SEPTEMBER = 8'h09;
  localparam logic [7:0] NOVEMBER = 8'h11;
  localparam logic [3:0] BCD_NINE = 4'h9;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Calendar state as seen outside
  typedef struct packed {
    logic [15:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [2:0] weekday;
  } calendar_t;

  // Captured register write
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wr_req_t;

  // One BCD digit plus one, wrapping 9 to 0
  function automatic logic [3:0] bcd_digit_inc(input logic [3:0] d);
    bcd_digit_inc = (d >= BCD_NINE) ? 4'h0 : 4'(d + 4'h1);
  endfunction

  // Two BCD digits form a multiple of four
  function automatic logic bcd_div4(input logic [3:0] tens, input logic [3:0] ones);
    if (tens[0]) begin
      bcd_div4 = (ones == 4'h2) || (ones == 4'h6);
    end else begin
      bcd_div4 = (ones == 4'h0) || (ones == 4'h4) || (ones == 4'h8);
    end
  endfunction

endpackage

// File: hdl/rtc_calendar_counters.sv
// Calendar counters of the real-time clock with an AXI4-Lite register slave
//
// Functional notes
// - Weekday advances on the same day carry that advances the date.
// - Weekday is three-bit binary, 000 Sunday to 110 Saturday, 111 reserved.
// - Weekday bits 7 to 3 read zero and ignore writes.
// - BCD date advances by one on each day carry from the hour counter.
// - Date ones digit counts 0 to 9, its carry bumps the tens digit.
// - Date tens in bits 5:4, ones in 3:0, bits 7:6 read zero.
// - Last valid date depends on month and leap year.
// - Leap year when year divides by 4, and by 400 when by 100.
// - Year value 0000 counts as a leap year.
// - BCD month advances by one on each month carry from the date.
// - Month tens in bit 4, ones in 3:0, bits 7:5 read zero.
// - Year is four BCD digits, thousands in 15:12 down to ones in 3:0.
// - Year advances by one on each year carry from the month.
// - Calendar counters keep their contents through every reset and standby.
`timescale 1ns/10ps
module rtc_calendar_counters #(
  parameter int ADDR_W = 8 // Register bus address width
) (
  input wire logic clk, // System clock, 125 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [ADDR_W-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic day_carry, // One-cycle day carry from the hour counter
  output rtc_cal_pkg::calendar_t calendar, // Current calendar state
  output logic year_carry // One-cycle pulse when the year advances
);

  // Calendar counters, never reset
  logic [2:0] weekday;
  logic [5:0] date;
  logic [4:0] month;
  logic [15:0] year;

  // Control state
  logic run;

  // Write channel bookkeeping
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  rtc_cal_pkg::wr_req_t wr_req;
  logic wr_fire;
  logic wr_mapped;

  // Decoded write enables
  logic wr_weekday;
  logic wr_date;
  logic wr_month;
  logic [1:0] wr_year;
  logic wr_ctrl;

  // Counting
  logic count_en;
  logic leap;
  logic [7:0] date_bcd;
  logic [7:0] month_bcd;
  logic [7:0] last_date;
  logic month_carry;
  logic next_year_carry;
  logic [2:0] next_weekday;
  logic [5:0] next_date;
  logic [4:0] next_month;
  logic [7:0] date_inc;
  logic [7:0] month_inc;

  // Read path
  logic [7:0] rd_addr;
  logic [31:0] next_rdata;
  logic next_rresp_err;

  // Register byte offset check against one of the documented words
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction

  // Last valid date of a month
  function automatic logic [7:0] month_last_date(input logic [7:0] m, input logic lp);
    if (m == rtc_cal_pkg::FEBRUARY) begin
      month_last_date = lp ? rtc_cal_pkg::DAYS_29 : rtc_cal_pkg::DAYS_28;
    end else if ((m == rtc_cal_pkg::APRIL) || (m == rtc_cal_pkg::JUNE) ||
                 (m == rtc_cal_pkg::SEPTEMBER) || (m == rtc_cal_pkg::NOVEMBER)) begin
      month_last_date = rtc_cal_pkg::DAYS_30;
    end else begin
      month_last_date = rtc_cal_pkg::DAYS_31;
    end
  endfunction

  // Two-digit BCD value plus one, a ones digit of 9 carrying into the tens
  function automatic logic [7:0] bcd_pair_inc(input logic [7:0] v);
    if (v[3:0] >= rtc_cal_pkg::BCD_NINE) begin
      bcd_pair_inc = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      bcd_pair_inc = {v[7:4], rtc_cal_pkg::bcd_digit_inc(v[3:0])};
    end
  endfunction

  // Write address channel: held until the response is taken
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awready <= 1'b1;
      aw_got <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (awready && awvalid) begin
      awready <= 1'b0;
      aw_got <= 1'b1;
      aw_addr_q <= 8'(awaddr);
    end else if (bvalid && bready) begin
      awready <= 1'b1;
      aw_got <= 1'b0;
    end
  end

  // Write data channel, taken in either order with the address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wready <= 1'b1;
      w_got <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wready && wvalid) begin
      wready <= 1'b0;
      w_got <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
      w_got <= 1'b0;
    end
  end

  // Write request once both halves are in
  always_comb begin
    wr_req.addr = aw_addr_q;
    wr_req.data = w_data_q;
    wr_req.strb = w_strb_q;
    wr_fire = aw_got && w_got && !bvalid;
    wr_mapped = addr_is(wr_req.addr, rtc_cal_pkg::WEEKDAY_OFS) ||
      addr_is(wr_req.addr, rtc_cal_pkg::DATE_OFS) ||
      addr_is(wr_req.addr, rtc_cal_pkg::MONTH_OFS) ||
      addr_is(wr_req.addr, rtc_cal_pkg::YEAR_OFS) ||
      addr_is(wr_req.addr, rtc_cal_pkg::CTRL_OFS);
  end

  // Byte-lane write enables per register
  always_comb begin
    wr_weekday = wr_fire && wr_req.strb[0] && addr_is(wr_req.addr, rtc_cal_pkg::WEEKDAY_OFS);
    wr_date = wr_fire && wr_req.strb[0] && addr_is(wr_req.addr, rtc_cal_pkg::DATE_OFS);
    wr_month = wr_fire && wr_req.strb[0] && addr_is(wr_req.addr, rtc_cal_pkg::MONTH_OFS);
    wr_ctrl = wr_fire && wr_req.strb[0] && addr_is(wr_req.addr, rtc_cal_pkg::CTRL_OFS);
    if (wr_fire && addr_is(wr_req.addr, rtc_cal_pkg::YEAR_OFS)) begin
      wr_year = wr_req.strb[1:0];
    end else begin
      wr_year = 2'b00;
    end
  end

  // Write response, error for an unmapped word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp <= rtc_cal_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_mapped ? rtc_cal_pkg::RESP_OKAY : rtc_cal_pkg::RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Count-stop control bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run <= rtc_cal_pkg::CTRL_RUN_RESET;
    end else if (wr_ctrl) begin
      run <= wr_req.data[rtc_cal_pkg::CTRL_RUN_BIT];
    end
  end

  // Leap year from the current year
  leap_year_detect u_leap (
    .year(year),
    .leap(leap)
  );

  // Day carry qualified by the count-stop bit; ignored while stopped
  always_comb begin
    count_en = day_carry && run;
    date_bcd = {2'b00, date};
    month_bcd = {3'b000, month};
    last_date = month_last_date(month_bcd, leap);
  end

  // Weekday step; the reserved code also falls back to Sunday
  always_comb begin
    if (weekday >= rtc_cal_pkg::SATURDAY) begin
      next_weekday = rtc_cal_pkg::SUNDAY;
    end else begin
      next_weekday = 3'(weekday + 3'h1);
    end
  end

  // Date step; at or past month end wraps, so a bad value cannot stick
  always_comb begin
    date_inc = bcd_pair_inc(date_bcd);
    if (date_bcd >= last_date) begin
      next_date = rtc_cal_pkg::DATE_FIRST[5:0];
      month_carry = 1'b1;
    end else begin
      next_date = date_inc[5:0];
      month_carry = 1'b0;
    end
  end

  // Month step and the year carry leaving it
  always_comb begin
    month_inc = bcd_pair_inc(month_bcd);
    if (month_bcd >= rtc_cal_pkg::MONTH_LAST) begin
      next_month = rtc_cal_pkg::MONTH_FIRST[4:0];
      next_year_carry = month_carry;
    end else begin
      next_month = month_inc[4:0];
      next_year_carry = 1'b0;
    end
  end

  // Weekday counter, not reset; a software write wins over counting
  always_ff @(posedge clk) begin
    if (wr_weekday) begin
      weekday <= wr_req.data[rtc_cal_pkg::WEEKDAY_MSB:0];
    end else if (count_en) begin
      weekday <= next_weekday;
    end
  end

  // Date counter, not reset
  always_ff @(posedge clk) begin
    if (wr_date) begin
      date <= wr_req.data[rtc_cal_pkg::DATE_MSB:0];
    end else if (count_en) begin
      date <= next_date;
    end
  end

  // Month counter, not reset
  always_ff @(posedge clk) begin
    if (wr_month) begin
      month <= wr_req.data[rtc_cal_pkg::MONTH_MSB:0];
    end else if (count_en && month_carry) begin
      month <= next_month;
    end
  end

  // Year counter
  bcd_year_counter u_year (
    .clk(clk),
    .inc(count_en && next_year_carry),
    .wr_en(wr_year),
    .wr_data(wr_req.data[rtc_cal_pkg::YEAR_MSB:0]),
    .year(year)
  );

  // Year carry pulse out
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      year_carry <= 1'b0;
    end else begin
      year_carry <= count_en && next_year_carry && (wr_year == 2'b00);
    end
  end

  // Calendar view straight from the counter flops
  always_comb begin
    calendar.year = year;
    calendar.month = month_bcd;
    calendar.date = date_bcd;
    calendar.weekday = weekday;
  end

  // Read data selection; reserved bits read zero
  always_comb begin
    rd_addr = 8'(araddr);
    next_rdata = 32'h0000_0000;
    next_rresp_err = 1'b0;
    if (addr_is(rd_addr, rtc_cal_pkg::WEEKDAY_OFS)) begin
      next_rdata[rtc_cal_pkg::WEEKDAY_MSB:0] = weekday;
    end else if (addr_is(rd_addr, rtc_cal_pkg::DATE_OFS)) begin
      next_rdata[rtc_cal_pkg::DATE_MSB:0] = date;
    end else if (addr_is(rd_addr, rtc_cal_pkg::MONTH_OFS)) begin
      next_rdata[rtc_cal_pkg::MONTH_MSB:0] = month;
    end else if (addr_is(rd_addr, rtc_cal_pkg::YEAR_OFS)) begin
      next_rdata[rtc_cal_pkg::YEAR_MSB:0] = year;
    end else if (addr_is(rd_addr, rtc_cal_pkg::CTRL_OFS)) begin
      next_rdata[rtc_cal_pkg::CTRL_RUN_BIT] = run;
      next_rdata[rtc_cal_pkg::CTRL_LEAP_BIT] = leap;
    end else begin
      next_rresp_err = 1'b1;
    end
  end

  // Read address and data channels
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= rtc_cal_pkg::RESP_OKAY;
    end else if (arready && arvalid) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rresp_err ? rtc_cal_pkg::RESP_SLVERR : rtc_cal_pkg::RESP_OKAY;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

endmodule

// File: tb/rtc_calendar_counters_monitor.sv
// Port-level assertions of the calendar counters
`timescale 1ns/10ps
module rtc_calendar_counters_monitor #(
  parameter int ADDR_W = 8 // Register bus address width
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Reset, active low
  input wire logic [ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  input wire logic arready, // Read address ready
  input wire logic [31:0] rdata, // Read data
  input wire logic rvalid, // Read data valid
  input wire logic bvalid, // Write response valid
  input wire logic day_carry, // Day carry in
  input wire rtc_cal_pkg::calendar_t calendar, // Calendar state
  input wire logic year_carry // Year carry out
);
  logic bv_q;
  wire logic wr = bvalid && !bv_q;
  wire logic [7:0] dt = calendar.date;
  wire logic [7:0] mo = calendar.month;
  wire logic [2:0] wd = calendar.weekday;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Delayed response valid, marks the edge a register write lands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bv_q <= 1'b0;
    end else begin
      bv_q <= bvalid;
    end
  end
  a_date_cause: assert property (!wr && $changed(dt) |-> $past(day_carry))
    else $error("date moved without day carry");
  a_week_with_date: assert property (!wr && $changed(dt) |-> $changed(wd))
    else $error("weekday did not follow date");
  a_weekday_step: assert property (!wr && $changed(wd)
    |-> wd == (($past(wd) >= 3'h6) ? 3'h0 : 3'($past(wd) + 3'h1)))
    else $error("weekday step wrong");
  a_date_step: assert property (!wr && $changed(dt) && dt != 8'h01
    |-> dt == 8'($past(dt) + (($past(dt[3:0]) == 4'h9) ? 8'h07 : 8'h01)))
    else $error("date step wrong");
  a_month_cause: assert property (!wr && $changed(mo)
    |-> dt == 8'h01 && $past(dt) >= 8'h28)
    else $error("month moved without date wrap");
  a_carry_source: assert property (year_carry |-> mo == 8'h01 && $past(mo) == 8'h12)
    else $error("year carry without month wrap");
  a_carry_pulse: assert property (year_carry |=> !year_carry)
    else $error("year carry longer than one cycle");
  a_year_cause: assert property (!wr && $changed(calendar.year) |-> year_carry)
    else $error("year moved without carry");
  a_weekday_read: assert property (arvalid && arready
    && araddr == rtc_cal_pkg::WEEKDAY_OFS
    |=> rvalid && rdata[31:3] == 29'h0)
    else $error("weekday upper bits not zero");
  c_year_roll: cover property (year_carry);
  c_month_roll: cover property (!wr && $changed(mo));
  c_weekday_wrap: cover property (!wr && wd == 3'h0 && $past(wd) == 3'h6);
endmodule
bind rtc_calendar_counters rtc_calendar_counters_monitor #(.ADDR_W(ADDR_W)) mon (.clk(clk),
  .nrst(nrst), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .bvalid(bvalid), .day_carry(day_carry), .calendar(calendar),
  .year_carry(year_carry));

// File: tb/rtc_calendar_counters_tb_top.sv
// Self-checking testbench of the calendar counters
`timescale 1ns/10ps
module rtc_calendar_counters_tb_top;
  localparam logic [1:0] OK = rtc_cal_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = rtc_cal_pkg::RESP_SLVERR;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, day_carry;
  logic awready, wready, bvalid, arready, rvalid, year_carry;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [3:0] wr_strb;
  logic [1:0] bresp, rresp;
  rtc_cal_pkg::calendar_t calendar;
  int failures = 0;
  int total_checks = 0;
  // Month ends and two mid-month steps: leap flag, year, month, date, next month, next date
  logic [48:0] cases [11] = '{49'h1_2000_0228_0229, 49'h0_1900_0228_0301,
    49'h1_2024_0229_0301, 49'h0_2023_0228_0301, 49'h1_0000_0228_0229,
    49'h0_2023_0430_0501, 49'h0_2023_0630_0701, 49'h0_2023_0930_1001,
    49'h0_2023_1130_1201, 49'h0_2023_0130_0131, 49'h0_2023_0809_0810};

  rtc_calendar_counters dut (.clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .day_carry(day_carry), .calendar(calendar), .year_carry(year_carry));

  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic give_up();
    failures++;
    final_report();
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_cal(input rtc_cal_pkg::calendar_t got, input rtc_cal_pkg::calendar_t exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write, address and data offered together
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= wr_strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 20) give_up();
    check_word({30'h0, bresp}, {30'h0, er});
  endtask

  // Bus read with data and response check
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 20) give_up();
    check_word(rdata, ed);
    check_word({30'h0, rresp}, {30'h0, er});
  endtask

  // Stop counting, then load all four counters
  task automatic set_cal(input logic [7:0] wd, input logic [7:0] dt, input logic [7:0] mo,
      input logic [15:0] yr);
    wr_chk(rtc_cal_pkg::CTRL_OFS, 32'h0, OK);
    wr_chk(rtc_cal_pkg::WEEKDAY_OFS, {24'h0, wd}, OK);
    wr_chk(rtc_cal_pkg::DATE_OFS, {24'h0, dt}, OK);
    wr_chk(rtc_cal_pkg::MONTH_OFS, {24'h0, mo}, OK);
    wr_chk(rtc_cal_pkg::YEAR_OFS, {16'h0, yr}, OK);
  endtask

  // Run, give n back-to-back day carries, stop again
  task automatic step(input int n, input logic ec);
    wr_chk(rtc_cal_pkg::CTRL_OFS, 32'h1, OK);
    @(posedge clk);
    day_carry <= 1'b1;
    repeat (n) @(posedge clk);
    day_carry <= 1'b0;
    @(posedge clk);
    check_word({31'h0, year_carry}, {31'h0, ec});
    wr_chk(rtc_cal_pkg::CTRL_OFS, 32'h0, OK);
  endtask

  task automatic test_regs();
    set_cal(8'hfd, 8'hc9, 8'hf2, 16'h1999);
    // Leap bit is only defined once the year is loaded
    rd_chk(rtc_cal_pkg::CTRL_OFS, 32'h0, OK);
    rd_chk(rtc_cal_pkg::WEEKDAY_OFS, 32'h5, OK);
    rd_chk(rtc_cal_pkg::DATE_OFS, 32'h9, OK);
    rd_chk(rtc_cal_pkg::MONTH_OFS, 32'h12, OK);
    rd_chk(rtc_cal_pkg::YEAR_OFS, 32'h1999, OK);
    check_cal(calendar, {16'h1999, 8'h12, 8'h09, 3'h5});
    rd_chk(8'h14, 32'h0, ERR);
    wr_chk(8'h14, 32'h1, ERR);
    // Byte lanes: year upper byte alone, weekday without lane 0
    wr_strb = 4'h2;
    wr_chk(rtc_cal_pkg::YEAR_OFS, 32'h0000_2000, OK);
    wr_chk(rtc_cal_pkg::WEEKDAY_OFS, 32'h0000_0003, OK);
    wr_strb = 4'hf;
    rd_chk(rtc_cal_pkg::YEAR_OFS, 32'h2099, OK);
    rd_chk(rtc_cal_pkg::WEEKDAY_OFS, 32'h5, OK);
    $display("test_regs done");
  endtask

  task automatic test_count();
    set_cal(8'h00, 8'h01, 8'h01, 16'h2023);
    step(9, 1'b0);
    check_cal(calendar, {16'h2023, 8'h01, 8'h10, 3'h2});
    set_cal(8'h06, 8'h31, 8'h12, 16'h1999);
    step(1, 1'b1);
    check_cal(calendar, {16'h2000, 8'h01, 8'h01, 3'h0});
    set_cal(8'h05, 8'h31, 8'h12, 16'h9999);
    step(1, 1'b1);
    check_cal(calendar, {16'h0000, 8'h01, 8'h01, 3'h6});
    $display("test_count done");
  endtask

  task automatic test_month_ends();
    logic [48:0] c;
    for (int i = 0; i < 11; i++) begin
      c = cases[i];
      set_cal(8'h03, c[23:16], c[31:24], c[47:32]);
      rd_chk(rtc_cal_pkg::CTRL_OFS, {30'h0, c[48], 1'b0}, OK);
      step(1, 1'b0);
      check_cal(calendar, {c[47:32], c[15:8], c[7:0], 3'h4});
    end
    $display("test_month_ends done");
  endtask

  // Reset mid-run, counters must survive and stay stopped
  task automatic test_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    day_carry <= 1'b1;
    @(posedge clk);
    day_carry <= 1'b0;
    rd_chk(rtc_cal_pkg::CTRL_OFS, 32'h0, OK);
    check_cal(calendar, {16'h2023, 8'h08, 8'h10, 3'h4});
    $display("test_reset done");
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    day_carry = 1'b0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wr_strb = 4'hf;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    test_regs();
    test_count();
    test_month_ends();
    test_reset();
    final_report();
  end

  // Watchdog for a hung run
  initial begin
    repeat (50000) @(posedge clk);
    give_up();
  end
endmodule
